//--- scbc_defs.vh
/*
  Constants for the SMBus control block of the clock fanout buffer: bus addresses, register
  indices, field positions and reset values.
  Assumes it is included by bare name from the design files of this block.
*/
`ifndef SCBC_DEFS_VH
`define SCBC_DEFS_VH

// ----------------------------------------------------------------
// Bus addresses, read/write bit included
// ----------------------------------------------------------------
`define SCBC_ADDR_WR 8'hd4
`define SCBC_ADDR_RD 8'hd5

// ----------------------------------------------------------------
// Register indices
// ----------------------------------------------------------------
`define SCBC_IDX_PLL_CONTROL 8'h00
`define SCBC_IDX_OUTPUT_GATE 8'h01
`define SCBC_IDX_FUNC_SPARE 8'h02
`define SCBC_IDX_MAKER_REV 8'h03
`define SCBC_IDX_PART_ID 8'h04
`define SCBC_IDX_READBACK_LEN 8'h05

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SCBC_PLL_REG_SEL_BIT 7
`define SCBC_LOOP_BW_BIT 1
`define SCBC_PLL_PATH_BIT 0
`define SCBC_PAIR5_BIT 5
`define SCBC_PAIR3_BIT 3
`define SCBC_PAIR2_BIT 2
`define SCBC_PAIR0_BIT 0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SCBC_RST_PLL_CONTROL 8'h83
`define SCBC_RST_OUTPUT_GATE 8'h2d
`define SCBC_RST_FUNC_SPARE 8'h00
`define SCBC_RST_READBACK_LEN 8'h06

// ----------------------------------------------------------------
// Serial framing
// ----------------------------------------------------------------
`define SCBC_BITS_PER_BYTE 4'h8

`endif

//--- scbc_regs.v
/*
  Register bank of the clock buffer control block: six byte registers, one write port
  and one registered read port, each with its own index.
  Assumes the serial engine presents a one-cycle write strobe as it starts to drive the byte's acknowledge.
*/
`default_nettype none
`include "scbc_defs.vh"

module scbc_regs #(
  parameter [3:0] REV_CODE = 4'h2,   // Arbitrary value.
  parameter [3:0] MAKER_CODE = 4'ha, // Arbitrary value.
  parameter [7:0] PART_ID = 8'h5a    // Arbitrary value.
) (
  input wire core_clk,
  input wire resetn,
  input wire wr_en,
  input wire [7:0] wr_idx,
  input wire [7:0] wr_data,
  input wire [7:0] rd_idx,
  output reg [7:0] rd_data_r,
  output reg [7:0] pll_control_r,
  output reg [7:0] output_gate_r,
  output reg [7:0] readback_len_r
);

  reg [7:0] func_spare_r;
  reg [7:0] rd_nxt;

  // ----------------------------------------------------------------
  // Writable registers
  // ----------------------------------------------------------------
  // Reserved bits power up undefined; they are cleared here so simulation starts clean.
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      pll_control_r <= `SCBC_RST_PLL_CONTROL;
      output_gate_r <= `SCBC_RST_OUTPUT_GATE;
      func_spare_r <= `SCBC_RST_FUNC_SPARE;
      readback_len_r <= `SCBC_RST_READBACK_LEN;
    end else if (wr_en) begin
      case (wr_idx)
        `SCBC_IDX_PLL_CONTROL: pll_control_r <= wr_data;
        `SCBC_IDX_OUTPUT_GATE: output_gate_r <= wr_data;
        `SCBC_IDX_FUNC_SPARE: func_spare_r <= wr_data;
        `SCBC_IDX_READBACK_LEN: readback_len_r <= wr_data;
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  always @* begin
    case (rd_idx)
      `SCBC_IDX_PLL_CONTROL: rd_nxt = pll_control_r;
      `SCBC_IDX_OUTPUT_GATE: rd_nxt = output_gate_r;
      `SCBC_IDX_FUNC_SPARE: rd_nxt = func_spare_r;
      `SCBC_IDX_MAKER_REV: rd_nxt = {REV_CODE, MAKER_CODE};
      `SCBC_IDX_PART_ID: rd_nxt = PART_ID;
      `SCBC_IDX_READBACK_LEN: rd_nxt = readback_len_r;
      default: rd_nxt = 8'h00;
    endcase
  end

  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rd_data_r <= 8'h00;
    end else begin
      rd_data_r <= rd_nxt;
    end
  end

endmodule // scbc_regs
`default_nettype wire

//--- scbc_top.v
/*
  SMBus target and control outputs of a six-output clock fanout buffer. The serial clock
  and data pins are oversampled by core_clk and decoded into block writes and block reads.
  Assumes core_clk runs at least six times faster than the serial clock and that the data
  pin is open drain with an external pull-up.
*/
`default_nettype none
`include "scbc_defs.vh"

// Contract
// - Answer at write D4, read D5.
// - Write: index, count, data bytes, all acknowledged.
// - Read: index, restart, count byte, then data.
// - Bit 7 selects pin or register PLL control.
// - Register bit 0 low bypasses the PLL; the code does so only while bit 7 is low.
// - Register 1 bits gate output pairs 5,3,2,0.
// - Reserved bits store writes, have no effect.
// - Registers 3 and 4 read-only identity codes.
// - Register 5 sets read-back length, default 6.
module scbc_top (
  input wire core_clk,
  input wire resetn,
  input wire smb_clk_in,
  input wire smb_dat_in,
  output reg smb_dat_out,
  output reg smb_dat_oe_n,
  input wire pll_bw_pin,
  output reg pll_register_control_select,
  output reg loop_bandwidth_select,
  output reg pll_path_enable,
  output reg output_pair5_gate,
  output reg output_pair3_gate,
  output reg output_pair2_gate,
  output reg output_pair0_gate
);

  localparam [6:0] ST_IDLE = 7'b0000001;
  localparam [6:0] ST_ADDR = 7'b0000010;
  localparam [6:0] ST_RXB = 7'b0000100;
  localparam [6:0] ST_ACK = 7'b0001000;
  localparam [6:0] ST_TX = 7'b0010000;
  localparam [6:0] ST_MACK = 7'b0100000;
  localparam [6:0] ST_MNEXT = 7'b1000000;

  reg scl_s1_r, scl_s2_r, scl_s3_r;
  reg sda_s1_r, sda_s2_r, sda_s3_r;
  reg bw_s1_r, bw_s2_r;
  reg [6:0] state_r;
  reg [7:0] shift_r;
  reg [7:0] tx_r;
  reg [3:0] cnt_r;
  reg [1:0] byte_num_r;
  reg rd_mode_r;
  reg count_sent_r;
  reg [7:0] ptr_r;
  reg [7:0] xfer_count_r;
  reg wr_en_r;
  reg [7:0] wr_idx_r;
  reg [7:0] wr_data_r;
  wire [7:0] rd_data;
  wire [7:0] pll_control;
  wire [7:0] output_gate;
  wire [7:0] readback_len;
  wire scl_rise, scl_fall, start_det, stop_det;

  // ----------------------------------------------------------------
  // Pin synchronisers and bus condition detection
  // ----------------------------------------------------------------
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      scl_s1_r <= 1'b1;
      scl_s2_r <= 1'b1;
      scl_s3_r <= 1'b1;
      sda_s1_r <= 1'b1;
      sda_s2_r <= 1'b1;
      sda_s3_r <= 1'b1;
      // Starts at the bandwidth output's reset level, so no low dip follows reset.
      bw_s1_r <= 1'b1;
      bw_s2_r <= 1'b1;
    end else begin
      scl_s1_r <= smb_clk_in;
      scl_s2_r <= scl_s1_r;
      scl_s3_r <= scl_s2_r;
      sda_s1_r <= smb_dat_in;
      sda_s2_r <= sda_s1_r;
      sda_s3_r <= sda_s2_r;
      bw_s1_r <= pll_bw_pin;
      bw_s2_r <= bw_s1_r;
    end
  end

  assign scl_rise = scl_s2_r & ~scl_s3_r;
  assign scl_fall = ~scl_s2_r & scl_s3_r;
  // A data edge only counts as start or stop while the clock is high on both samples.
  assign start_det = scl_s2_r & scl_s3_r & sda_s3_r & ~sda_s2_r;
  assign stop_det = scl_s2_r & scl_s3_r & ~sda_s3_r & sda_s2_r;

  // ----------------------------------------------------------------
  // Serial engine
  // ----------------------------------------------------------------
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_r <= ST_IDLE;
      shift_r <= 8'h00;
      tx_r <= 8'h00;
      cnt_r <= 4'h0;
      byte_num_r <= 2'b00;
      rd_mode_r <= 1'b0;
      count_sent_r <= 1'b0;
      ptr_r <= 8'h00;
      xfer_count_r <= 8'h00;
      wr_en_r <= 1'b0;
      wr_idx_r <= 8'h00;
      wr_data_r <= 8'h00;
      smb_dat_out <= 1'b0;
      smb_dat_oe_n <= 1'b1;
    end else begin
      wr_en_r <= 1'b0;
      smb_dat_out <= 1'b0;
      if (stop_det) begin
        state_r <= ST_IDLE;
        smb_dat_oe_n <= 1'b1;
      end else if (start_det) begin
        state_r <= ST_ADDR;
        cnt_r <= 4'h0;
        smb_dat_oe_n <= 1'b1;
      end else begin
        case (state_r)
          ST_ADDR, ST_RXB: begin
            if (scl_rise) begin
              shift_r <= {shift_r[6:0], sda_s2_r};
              cnt_r <= cnt_r + 4'h1;
            end else if (scl_fall && cnt_r == `SCBC_BITS_PER_BYTE) begin
              state_r <= ST_ACK;
              smb_dat_oe_n <= 1'b0;
              if (state_r == ST_ADDR) begin
                if (shift_r == `SCBC_ADDR_WR) begin
                  rd_mode_r <= 1'b0;
                  byte_num_r <= 2'b00;
                end else if (shift_r == `SCBC_ADDR_RD) begin
                  rd_mode_r <= 1'b1;
                  count_sent_r <= 1'b0;
                end else begin
                  state_r <= ST_IDLE;
                  smb_dat_oe_n <= 1'b1;
                end
              end else begin
                if (byte_num_r != 2'b11) begin
                  byte_num_r <= byte_num_r + 2'b01;
                end
                case (byte_num_r)
                  2'b00: ptr_r <= shift_r;
                  2'b01: xfer_count_r <= shift_r;
                  default: begin
                    // The byte is committed while its acknowledge is driven.
                    wr_en_r <= 1'b1;
                    wr_idx_r <= ptr_r;
                    wr_data_r <= shift_r;
                    ptr_r <= ptr_r + 8'h01;
                  end
                endcase
              end
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              cnt_r <= 4'h0;
              if (rd_mode_r) begin
                state_r <= ST_TX;
                tx_r <= readback_len;
                smb_dat_oe_n <= readback_len[7];
              end else begin
                state_r <= ST_RXB;
                smb_dat_oe_n <= 1'b1;
              end
            end
          end
          ST_TX: begin
            if (scl_rise) begin
              cnt_r <= cnt_r + 4'h1;
            end else if (scl_fall) begin
              if (cnt_r == `SCBC_BITS_PER_BYTE) begin
                state_r <= ST_MACK;
                smb_dat_oe_n <= 1'b1;
                if (count_sent_r) begin
                  ptr_r <= ptr_r + 8'h01;
                end
                count_sent_r <= 1'b1;
              end else begin
                smb_dat_oe_n <= tx_r[6];
                tx_r <= {tx_r[6:0], 1'b0};
              end
            end
          end
          ST_MACK: begin
            if (scl_rise) begin
              // A refused byte ends the read; the line stays released until stop.
              state_r <= sda_s2_r ? ST_IDLE : ST_MNEXT;
            end
          end
          ST_MNEXT: begin
            if (scl_fall) begin
              state_r <= ST_TX;
              cnt_r <= 4'h0;
              tx_r <= rd_data;
              smb_dat_oe_n <= rd_data[7];
            end
          end
          default: begin
            state_r <= ST_IDLE;
            smb_dat_oe_n <= 1'b1;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Register bank
  // ----------------------------------------------------------------
  scbc_regs u_regs (
    .core_clk(core_clk),
    .resetn(resetn),
    .wr_en(wr_en_r),
    .wr_idx(wr_idx_r),
    .wr_data(wr_data_r),
    .rd_idx(ptr_r),
    .rd_data_r(rd_data),
    .pll_control_r(pll_control),
    .output_gate_r(output_gate),
    .readback_len_r(readback_len)
  );

  // ----------------------------------------------------------------
  // Control outputs
  // ----------------------------------------------------------------
  // These only steer the clock path, never the serial engine, so a write cannot upset
  // the transfer that carries it.
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      pll_register_control_select <= 1'b1;
      loop_bandwidth_select <= 1'b1;
      pll_path_enable <= 1'b1;
      output_pair5_gate <= 1'b1;
      output_pair3_gate <= 1'b1;
      output_pair2_gate <= 1'b1;
      output_pair0_gate <= 1'b1;
    end else begin
      pll_register_control_select <= pll_control[`SCBC_PLL_REG_SEL_BIT];
      loop_bandwidth_select <= pll_control[`SCBC_PLL_REG_SEL_BIT] ?
        bw_s2_r : pll_control[`SCBC_LOOP_BW_BIT];
      pll_path_enable <= pll_control[`SCBC_PLL_REG_SEL_BIT] |
        pll_control[`SCBC_PLL_PATH_BIT];
      output_pair5_gate <= output_gate[`SCBC_PAIR5_BIT];
      output_pair3_gate <= output_gate[`SCBC_PAIR3_BIT];
      output_pair2_gate <= output_gate[`SCBC_PAIR2_BIT];
      output_pair0_gate <= output_gate[`SCBC_PAIR0_BIT];
    end
  end

endmodule // scbc_top
`default_nettype wire

//--- scbc_chk.sv
/*
  Port checker for the SMBus control block of the clock fanout buffer.
  Assumes it is bound to scbc_top and that the data wire is open drain with a pull-up.
*/
`default_nettype none
module scbc_chk (
  input wire core_clk,
  input wire resetn,
  input wire smb_clk_in,
  input wire smb_dat_in,
  input wire smb_dat_out,
  input wire smb_dat_oe_n,
  input wire pll_bw_pin,
  input wire pll_register_control_select,
  input wire loop_bandwidth_select,
  input wire pll_path_enable,
  input wire output_pair5_gate,
  input wire output_pair3_gate,
  input wire output_pair2_gate,
  input wire output_pair0_gate
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // Relations between the pins
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);
  dat_low_a: assert property (smb_dat_out == 1'b0)
    else $error("data pin driven high");
  path_sel_a: assert property (pll_register_control_select |-> pll_path_enable)
    else $error("bypass while pins control the loop");
  bw_pin_a: assert property ((pll_register_control_select && $stable(pll_bw_pin))[*5]
    |-> loop_bandwidth_select == pll_bw_pin) else $error("bandwidth does not follow its pin");
  // The line may only move while the serial clock is low, else a stray start or stop appears.
  oe_edge_a: assert property ($changed(smb_dat_oe_n) |-> !$past(smb_clk_in, 2))
    else $error("data line moved while clock high");
  gate5_a: assert property ($changed(output_pair5_gate) |-> !smb_dat_oe_n)
    else $error("pair 5 gate moved outside an acknowledge");
  gate0_a: assert property ($changed(output_pair0_gate) |-> !smb_dat_oe_n)
    else $error("pair 0 gate moved outside an acknowledge");
  sel_ack_a: assert property ($changed(pll_register_control_select) |-> !smb_dat_oe_n)
    else $error("control select moved outside an acknowledge");
  bw_reg_a: assert property (!pll_register_control_select && $changed(loop_bandwidth_select)
    |-> !smb_dat_oe_n) else $error("register bandwidth moved outside an acknowledge");
endmodule // scbc_chk
`default_nettype wire

//--- scbc_host.sv
/*
  Behavioural SMBus host that drives the serial clock and data and reads the wire back.
  Assumes the bench resolves the open-drain wire and feeds its level to sda.
*/
`default_nettype none
module scbc_host (
  input wire logic core_clk,
  input wire logic sda,
  output var logic scl,
  output var logic sda_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // Bit and byte framing, one bit each eight system clocks
  // ----------------------------------------------------------------
  initial begin
    scl = 1'b1;
    sda_o = 1'b1;
  end
  task tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  // Serves as start and as repeated start; the clock stays high between frames.
  task start();
    sda_o = 1'b1;
    tick(2);
    scl = 1'b1;
    tick(4);
    sda_o = 1'b0;
    tick(4);
    scl = 1'b0;
    tick(2);
  endtask
  task put_bit(input logic b);
    sda_o = b;
    tick(2);
    scl = 1'b1;
    tick(4);
    scl = 1'b0;
    tick(2);
  endtask
  task get_bit(output logic b);
    sda_o = 1'b1;
    tick(2);
    scl = 1'b1;
    tick(2);
    b = sda;
    tick(2);
    scl = 1'b0;
    tick(2);
  endtask
  task send_byte(input logic [7:0] d, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) put_bit(d[i]);
    get_bit(a);
    ack = (a === 1'b0);
  endtask
  // The last byte of a read is refused so that the target lets go of the line.
  task recv_byte(output logic [7:0] d, input logic last);
    for (int i = 7; i >= 0; i--) get_bit(d[i]);
    put_bit(last);
  endtask
  task stop();
    sda_o = 1'b0;
    tick(2);
    scl = 1'b1;
    tick(4);
    sda_o = 1'b1;
    tick(4);
  endtask
endmodule // scbc_host
`default_nettype wire

//--- testbench.sv
/*
  Self-checking bench for scbc_top, driven through the SMBus host model.
  Assumes a 50 MHz system clock and a pull-up on the data wire.
*/
`default_nettype none
`include "scbc_defs.vh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk, resetn, pll_bw_pin;
  wire logic smb_clk_in, host_sda, smb_dat_out, smb_dat_oe_n, pll_register_control_select;
  wire logic loop_bandwidth_select, pll_path_enable, output_pair5_gate, output_pair3_gate;
  wire logic output_pair2_gate, output_pair0_gate;
  wire logic smb_dat_in = host_sda & (smb_dat_oe_n | smb_dat_out);
  wire logic [7:0] outs = {1'b0, pll_register_control_select, loop_bandwidth_select, pll_path_enable,
    output_pair5_gate, output_pair3_gate, output_pair2_gate, output_pair0_gate};
  int err_count, checked;
  scbc_top DUT (
    .core_clk(core_clk),
    .resetn(resetn),
    .smb_clk_in(smb_clk_in),
    .smb_dat_in(smb_dat_in),
    .smb_dat_out(smb_dat_out),
    .smb_dat_oe_n(smb_dat_oe_n),
    .pll_bw_pin(pll_bw_pin),
    .pll_register_control_select(pll_register_control_select),
    .loop_bandwidth_select(loop_bandwidth_select),
    .pll_path_enable(pll_path_enable),
    .output_pair5_gate(output_pair5_gate),
    .output_pair3_gate(output_pair3_gate),
    .output_pair2_gate(output_pair2_gate),
    .output_pair0_gate(output_pair0_gate)
  );
  scbc_host u_host (.core_clk(core_clk), .sda(smb_dat_in), .scl(smb_clk_in), .sda_o(host_sda));
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task chk(input logic [7:0] got, input logic [7:0] want);
    checked++;
    if (got !== want) begin
      err_count++;
      $display("ERROR t=%0t got=%h want=%h", $time, got, want);
    end
  endtask
  task sb(input logic [7:0] d, input logic want);
    logic a;
    u_host.send_byte(d, a);
    chk({7'h00, a}, {7'h00, want});
  endtask
  task wr(input logic [7:0] idx, input int n, input logic [31:0] d);
    u_host.start();
    sb(`SCBC_ADDR_WR, 1'b1);
    sb(idx, 1'b1);
    sb(8'(n), 1'b1);
    for (int k = 0; k < n; k++) sb(d[8*k+:8], 1'b1);
    u_host.stop();
  endtask
  task rd(input logic [7:0] idx, input int n, input logic [63:0] e);
    logic [7:0] b;
    u_host.start();
    sb(`SCBC_ADDR_WR, 1'b1);
    sb(idx, 1'b1);
    u_host.start();
    sb(`SCBC_ADDR_RD, 1'b1);
    for (int k = 0; k < n; k++) begin
      u_host.recv_byte(b, k == n - 1);
      chk(b, e[8*k+:8]);
    end
    u_host.stop();
  endtask
  task report_and_stop();
    $display("checks=%0d mismatches=%0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task t_reset();
    chk(outs, 8'h7f);
    rd(`SCBC_IDX_PLL_CONTROL, 7, 64'h00065a2a002d8306);
    $display("test reset done");
  endtask
  task t_bad();
    u_host.start();
    sb(8'hd6, 1'b0);
    u_host.stop();
    chk({7'h00, smb_dat_oe_n}, 8'h01);
    $display("test bad address done");
  endtask
  task t_write();
    wr(`SCBC_IDX_PLL_CONTROL, 2, 32'hd27c);
    chk(outs, 8'h00);
    rd(`SCBC_IDX_PLL_CONTROL, 3, 64'hd27c06);
    wr(`SCBC_IDX_OUTPUT_GATE, 1, 32'h28);
    chk(outs, 8'h0c);
    $display("test write done");
  endtask
  task t_bw();
    wr(`SCBC_IDX_PLL_CONTROL, 1, 32'h02);
    chk(outs, 8'h2c);
    pll_bw_pin = 1'b0;
    wr(`SCBC_IDX_PLL_CONTROL, 1, 32'h81);
    chk(outs, 8'h5c);
    pll_bw_pin = 1'b1;
    u_host.tick(6);
    chk(outs, 8'h7c);
    $display("test bandwidth done");
  endtask
  task t_ro();
    wr(`SCBC_IDX_MAKER_REV, 2, 32'h00ff);
    wr(`SCBC_IDX_READBACK_LEN, 1, 32'h02);
    rd(`SCBC_IDX_MAKER_REV, 3, 64'h5a2a02);
    wr(`SCBC_IDX_FUNC_SPARE, 1, 32'ha5);
    chk(outs, 8'h7c);
    rd(`SCBC_IDX_FUNC_SPARE, 4, 64'h5a2aa502);
    $display("test read-only done");
  endtask
  // ----------------------------------------------------------------
  // Clock, reset, sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  initial begin
    resetn = 1'b0;
    pll_bw_pin = 1'b1;
    err_count = 0;
    checked = 0;
    repeat (2) @(posedge core_clk);
    #1;
    resetn = 1'b1;
    u_host.tick(4);
    t_reset();
    t_bad();
    t_write();
    t_bw();
    t_ro();
    report_and_stop();
  end
  // The tests need well under 0.2 ms; five times that is allowed before giving up.
  initial begin
    #1000000;
    err_count++;
    report_and_stop();
  end
endmodule // testbench
bind scbc_top scbc_chk u_chk (
  .core_clk(core_clk),
  .resetn(resetn),
  .smb_clk_in(smb_clk_in),
  .smb_dat_in(smb_dat_in),
  .smb_dat_out(smb_dat_out),
  .smb_dat_oe_n(smb_dat_oe_n),
  .pll_bw_pin(pll_bw_pin),
  .pll_register_control_select(pll_register_control_select),
  .loop_bandwidth_select(loop_bandwidth_select),
  .pll_path_enable(pll_path_enable),
  .output_pair5_gate(output_pair5_gate),
  .output_pair3_gate(output_pair3_gate),
  .output_pair2_gate(output_pair2_gate),
  .output_pair0_gate(output_pair0_gate)
);
`default_nettype wire
